// ===== inc/asc_pkg.sv
// shared constants for the converter sequencer control block
package asc_pkg;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_RESULT = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h08;
  localparam int CONV_DONE_BIT = 7;
  localparam int IRQ_ENABLE_BIT = 6;
  localparam int CONTINUOUS_BIT = 5;
  localparam int CLK_SOURCE_BIT = 4;
  localparam int PRESCALE_LSB = 5;
  localparam logic [4:0] CHANNEL_RESET = 5'h1f;
  localparam logic [4:0] CHANNEL_POWER_OFF = 5'h1f;
  localparam logic [4:0] CHANNEL_LOW_REF = 5'h1e;
  localparam logic [4:0] CHANNEL_HIGH_REF = 5'h1d;
  localparam logic [4:0] CHANNEL_LAST_EXT = 5'h0e;
  localparam logic [4:0] CHANNEL_FIRST_PORT_D = 5'h08;
  localparam logic [4:0] CHANNEL_RESERVED = 5'h1b;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam int SAR_BITS = 8;
  localparam logic [4:0] SAMPLE_TICKS = 5'h08;
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [4:0] ROUTE_HIGH_REF = 5'h10;
  localparam logic [4:0] ROUTE_LOW_REF = 5'h11;
  localparam logic [4:0] ROUTE_NONE = 5'h12;
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_SAMPLE = 2'b01,
    ASC_BITS = 2'b11,
    ASC_DONE = 2'b10
  } asc_state_e;
endpackage

// ===== core/asc_prescaler.sv
// converter clock tick generator with source select and prescale
`timescale 1ns/1ps
`default_nettype none
module asc_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic crystal_tick,
  input wire logic bus_source,
  input wire logic [2:0] clock_prescale,
  input wire logic run,
  output logic conv_tick
);
  logic [3:0] div_reg;
  logic [3:0] limit;
  logic src_tick;

  always_comb begin
    src_tick = bus_source ? 1'b1 : crystal_tick;
    case (clock_prescale)
      3'h0: limit = 4'h0;
      3'h1: limit = 4'h1;
      3'h2: limit = 4'h3;
      3'h3: limit = 4'h7;
      default: limit = 4'hf;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 4'h0;
      conv_tick <= 1'b0;
    end else if (!run) begin
      div_reg <= 4'h0;
      conv_tick <= 1'b0;
    end else if (src_tick) begin
      conv_tick <= (div_reg >= limit);
      div_reg <= (div_reg >= limit) ? 4'h0 : div_reg + 4'h1;
    end else begin
      conv_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/asc_sar.sv
// successive approximation register, one bit per converter tick
`timescale 1ns/1ps
`default_nettype none
module asc_sar #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic load,
  input wire logic step,
  input wire logic comp_above,
  output logic [WIDTH-1:0] trial,
  output logic finished
);
  logic [WIDTH-1:0] mask_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial <= '0;
      mask_reg <= '0;
      finished <= 1'b0;
    end else if (clear) begin
      trial <= '0;
      mask_reg <= '0;
      finished <= 1'b0;
    end else if (load) begin
      trial <= {1'b1, {(WIDTH-1){1'b0}}};
      mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      finished <= 1'b0;
    end else if (step && mask_reg != '0) begin
      // keep trial bit when input is above trial level, then try next bit
      trial <= (comp_above ? trial : (trial & ~mask_reg)) | (mask_reg >> 1);
      mask_reg <= mask_reg >> 1;
      finished <= (mask_reg == {{(WIDTH-1){1'b0}}, 1'b1});
    end else begin
      finished <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/asc_top.sv
// converter sequencer control: APB registers, channel mux, conversion sequence
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - with irq enable set, raise interrupt at end of each conversion; reset clears enable
// - result read or status write drops pending interrupt
// - continuous bit keeps converting and refreshing result; reset clears it
// - continuous bit clear: one conversion per start, then stop
// - five-bit channel select picks one of fifteen external inputs
// - codes 0-7 route port B 0-7, codes 8-14 port D 0-6
// - channel code all ones powers converter off; reset sets it
// - unused codes give undefined result; one code reserved
// - codes just below power-off route high and low references
// - one eight-bit result register rewritten per conversion
// - three-bit prescale divides by 1,2,4,8, or 16 when top bit set
// - clock source bit: one bus clock, zero crystal; reset crystal
// - status write starts conversion lasting sixteen to seventeen converter clocks
// - continuous results overwrite previous, read or not
// - done flag set per conversion, cleared by status write or result read
// - stop mode aborts conversion and holds block inactive
module asc_top (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CRYSTAL_CLOCK,
  input wire logic STOP_MODE,
  input wire logic COMP_ABOVE,
  output logic [4:0] SELECTED_ANALOG_INPUT,
  output logic [7:0] SAR_TRIAL,
  output logic CONVERTER_POWER_ON,
  output logic SAMPLE_HOLD,
  output logic CONV_IRQ
);
  logic rst_meta_reg, rst_n;
  logic xtal_s1_reg, xtal_s2_reg, xtal_s3_reg;
  logic stop_s1_reg, stop_reg;
  logic comp_s1_reg, comp_reg;
  logic conv_irq_enable, continuous_convert, conv_done_flag, clock_source_select;
  logic [4:0] channel_select;
  logic [2:0] clock_prescale;
  logic [7:0] result_reg;
  asc_pkg::asc_state_e state_reg, state_next;
  logic [4:0] tick_cnt_reg;
  logic start_pend_reg;
  logic conv_tick, sar_finished, sar_load, sar_clear;
  logic [7:0] sar_trial;
  logic apb_access, apb_wr, apb_rd, wr_status, rd_result, powered, running;

  function automatic logic [4:0] route_of(input logic [4:0] code);
    if (code <= asc_pkg::CHANNEL_LAST_EXT)
      route_of = code;
    else if (code == asc_pkg::CHANNEL_HIGH_REF)
      route_of = asc_pkg::ROUTE_HIGH_REF;
    else if (code == asc_pkg::CHANNEL_LOW_REF)
      route_of = asc_pkg::ROUTE_LOW_REF;
    else
      route_of = asc_pkg::ROUTE_NONE;
  endfunction

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // crystal clock is sampled; its rising edge is a tick on the bus clock
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      xtal_s1_reg <= 1'b0;
      xtal_s2_reg <= 1'b0;
      xtal_s3_reg <= 1'b0;
      stop_s1_reg <= 1'b0;
      stop_reg <= 1'b0;
      comp_s1_reg <= 1'b0;
      comp_reg <= 1'b0;
    end else begin
      xtal_s1_reg <= CRYSTAL_CLOCK;
      xtal_s2_reg <= xtal_s1_reg;
      xtal_s3_reg <= xtal_s2_reg;
      stop_s1_reg <= STOP_MODE;
      stop_reg <= stop_s1_reg;
      comp_s1_reg <= COMP_ABOVE;
      comp_reg <= comp_s1_reg;
    end
  end

  assign apb_access = PSEL && PENABLE;
  assign apb_wr = apb_access && PWRITE;
  assign apb_rd = apb_access && !PWRITE;
  assign wr_status = apb_wr && PADDR == asc_pkg::ADDR_STATUS_CONTROL;
  assign rd_result = apb_rd && PADDR == asc_pkg::ADDR_RESULT;
  assign powered = channel_select != asc_pkg::CHANNEL_POWER_OFF;
  assign running = state_reg != asc_pkg::ASC_IDLE;

  // zero-wait slave: every access completes in its first access cycle
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && PADDR != asc_pkg::ADDR_STATUS_CONTROL
        && PADDR != asc_pkg::ADDR_RESULT && PADDR != asc_pkg::ADDR_CLOCK_SELECT;
      PRDATA <= 32'h0;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          asc_pkg::ADDR_STATUS_CONTROL:
            PRDATA <= {24'h0, conv_done_flag, conv_irq_enable, continuous_convert,
                       channel_select};
          asc_pkg::ADDR_RESULT: PRDATA <= {24'h0, result_reg};
          asc_pkg::ADDR_CLOCK_SELECT:
            PRDATA <= {24'h0, clock_prescale, clock_source_select, 4'h0};
          default: PRDATA <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      conv_irq_enable <= 1'b0;
      continuous_convert <= 1'b0;
      channel_select <= asc_pkg::CHANNEL_RESET;
    end else if (wr_status && PREADY) begin
      conv_irq_enable <= PWDATA[asc_pkg::IRQ_ENABLE_BIT];
      continuous_convert <= PWDATA[asc_pkg::CONTINUOUS_BIT];
      channel_select <= PWDATA[4:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clock_source_select <= 1'b0;
      clock_prescale <= asc_pkg::PRESCALE_RESET;
    end else if (apb_wr && PREADY && PADDR == asc_pkg::ADDR_CLOCK_SELECT) begin
      clock_source_select <= PWDATA[asc_pkg::CLK_SOURCE_BIT];
      clock_prescale <= PWDATA[asc_pkg::PRESCALE_LSB +: 3];
    end
  end

  // a status write restarts a conversion past its sample phase; stop mode discards any pending start
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n)
      start_pend_reg <= 1'b0;
    else if (stop_reg)
      start_pend_reg <= 1'b0;
    else if (wr_status && PREADY)
      start_pend_reg <= 1'b1;
    else if (state_reg == asc_pkg::ASC_SAMPLE)
      start_pend_reg <= 1'b0;
  end

  asc_prescaler u_prescaler (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .crystal_tick(xtal_s2_reg && !xtal_s3_reg),
    .bus_source(clock_source_select),
    .clock_prescale(clock_prescale),
    .run(running),
    .conv_tick(conv_tick)
  );

  assign sar_clear = stop_reg || !powered || start_pend_reg && state_reg != asc_pkg::ASC_IDLE
    && state_reg != asc_pkg::ASC_SAMPLE;
  assign sar_load = state_reg == asc_pkg::ASC_SAMPLE && conv_tick
    && tick_cnt_reg == asc_pkg::SAMPLE_TICKS - 5'h1;

  asc_sar #(.WIDTH(asc_pkg::SAR_BITS)) u_sar (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .clear(sar_clear),
    .load(sar_load),
    .step(state_reg == asc_pkg::ASC_BITS && conv_tick),
    .comp_above(comp_reg),
    .trial(sar_trial),
    .finished(sar_finished)
  );

  // sample for eight ticks then eight bit decisions: sixteen ticks plus sync slack
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      asc_pkg::ASC_IDLE:
        if (start_pend_reg && powered)
          state_next = asc_pkg::ASC_SAMPLE;
      asc_pkg::ASC_SAMPLE:
        if (sar_load)
          state_next = asc_pkg::ASC_BITS;
      asc_pkg::ASC_BITS:
        if (sar_finished)
          state_next = asc_pkg::ASC_DONE;
      asc_pkg::ASC_DONE:
        state_next = continuous_convert ? asc_pkg::ASC_SAMPLE : asc_pkg::ASC_IDLE;
      default:
        state_next = asc_pkg::ASC_IDLE;
    endcase
    if (sar_clear && !(start_pend_reg && powered && !stop_reg))
      state_next = asc_pkg::ASC_IDLE;
    else if (sar_clear)
      state_next = asc_pkg::ASC_SAMPLE;
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n)
      state_reg <= asc_pkg::ASC_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n)
      tick_cnt_reg <= 5'h0;
    else if (state_reg != state_next || state_reg == asc_pkg::ASC_DONE)
      tick_cnt_reg <= 5'h0;
    else if (conv_tick)
      tick_cnt_reg <= tick_cnt_reg + 5'h1;
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n)
      result_reg <= 8'h0;
    else if (state_reg == asc_pkg::ASC_DONE)
      result_reg <= sar_trial;
  end

  // completion beats a same-cycle clear so no result goes unflagged
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n)
      conv_done_flag <= 1'b0;
    else if (state_reg == asc_pkg::ASC_DONE)
      conv_done_flag <= 1'b1;
    else if ((wr_status || rd_result) && PREADY)
      conv_done_flag <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CONV_IRQ <= 1'b0;
      SELECTED_ANALOG_INPUT <= asc_pkg::ROUTE_NONE;
      SAR_TRIAL <= 8'h0;
      CONVERTER_POWER_ON <= 1'b0;
      SAMPLE_HOLD <= 1'b0;
    end else begin
      CONV_IRQ <= conv_done_flag && conv_irq_enable;
      SELECTED_ANALOG_INPUT <= route_of(channel_select);
      SAR_TRIAL <= sar_trial;
      CONVERTER_POWER_ON <= powered && !stop_reg;
      SAMPLE_HOLD <= state_reg == asc_pkg::ASC_SAMPLE;
    end
  end

  chk_done_sets_flag: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    state_reg == asc_pkg::ASC_DONE |=> conv_done_flag)
    else $error("done flag not set after conversion");
  chk_irq_follows_flag: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    conv_done_flag && conv_irq_enable |=> CONV_IRQ)
    else $error("interrupt not raised");
  chk_read_drops_irq: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    rd_result && PREADY && state_reg != asc_pkg::ASC_DONE |=> ##1 !CONV_IRQ)
    else $error("interrupt not dropped by read");
  chk_single_stops: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    state_reg == asc_pkg::ASC_DONE && !continuous_convert |=> state_reg == asc_pkg::ASC_IDLE
    || start_pend_reg)
    else $error("single conversion did not stop");
  chk_cont_restarts: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    state_reg == asc_pkg::ASC_DONE && continuous_convert && !sar_clear
    |=> state_reg == asc_pkg::ASC_SAMPLE)
    else $error("continuous mode did not restart");
  chk_result_update: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    state_reg == asc_pkg::ASC_DONE |=> result_reg == $past(sar_trial))
    else $error("result not captured");
  chk_power_off: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    !powered |=> state_reg == asc_pkg::ASC_IDLE && !CONVERTER_POWER_ON)
    else $error("converter not powered down");
  chk_stop_aborts: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    stop_reg |=> state_reg == asc_pkg::ASC_IDLE && !start_pend_reg)
    else $error("stop did not abort conversion");
  chk_route_map: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    channel_select == asc_pkg::CHANNEL_FIRST_PORT_D
    |=> SELECTED_ANALOG_INPUT == asc_pkg::CHANNEL_FIRST_PORT_D)
    else $error("channel routing wrong");
endmodule
`default_nettype wire

// ===== bench/asc_comp_model.sv
// comparator and analog mux model on the far side of the converter
`timescale 1ns/1ps
`default_nettype none
module asc_comp_model (
  input wire logic clk,
  input wire logic [4:0] sel,
  input wire logic [7:0] trial,
  output logic comp_above
);
  logic [7:0] level;
  logic wobble = 1'b0;
  always @(posedge clk) begin
    wobble <= ~wobble;
  end
  always_comb begin
    if (sel < 5'h0f) begin
      level = {sel[3:0], 4'h5};
    end else if (sel == 5'h10) begin
      level = 8'hff;
    end else begin
      level = 8'h00;
    end
  end
  // unrouted input floats: toggling keeps a bad route from looking settled
  assign comp_above = (sel > 5'h11) ? wobble : (level >= trial);
endmodule
`default_nettype wire

// ===== bench/adc_sequencer_control_tb.sv
// self-checking bench for the converter sequencer control block
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_tb;
  localparam logic [7:0] SC = asc_pkg::ADDR_STATUS_CONTROL;
  localparam logic [7:0] RS = asc_pkg::ADDR_RESULT;
  localparam logic [7:0] CK = asc_pkg::ADDR_CLOCK_SELECT;
  logic clk, rst_n, psel, penable, pwrite, xclk, stop, comp, pready, pslverr, pwr_on, sh, irq;
  logic [7:0] paddr, trial, ev;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] route, er;
  logic err;
  int n_errors = 0;
  int cmp_count = 0;
  int n, w, dv;

  asc_top i_dut (.SYS_CLK(clk), .NRST(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CRYSTAL_CLOCK(xclk), .STOP_MODE(stop), .COMP_ABOVE(comp),
    .SELECTED_ANALOG_INPUT(route), .SAR_TRIAL(trial), .CONVERTER_POWER_ON(pwr_on),
    .SAMPLE_HOLD(sh), .CONV_IRQ(irq));
  asc_comp_model i_comp (.clk(clk), .sel(route), .trial(trial), .comp_above(comp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // crystal at 64 ns, phase unrelated to the bus clock
  initial begin
    xclk = 1'b0;
    #13;
    forever #32 xclk = ~xclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // request stands until the edge that samples pready high
    @(posedge clk);
    while (pready !== 1'b1 && t < 50) begin
      @(posedge clk);
      t++;
    end
    if (t >= 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_done();
    int i;
    i = 0;
    rd = 32'h0;
    while (rd[7] !== 1'b1 && i < 500) begin
      apb(1'b0, SC, 32'h0);
      i++;
    end
    check(32'(rd[7]), 32'h1);
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask

  // counts sample phase starts over a span of cycles
  task automatic count_sh(input int cyc);
    logic prev;
    prev = sh;
    n = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (sh && !prev) n++;
      prev = sh;
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stop = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(32'(route), 32'h12);
    check(32'(pwr_on), 32'h0);
    apb(1'b0, SC, 32'h0);
    check(rd, 32'h1f);
    apb(1'b0, CK, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, CK, 32'hff);
    apb(1'b0, CK, 32'h0);
    check(rd, 32'hf0);
    apb(1'b1, CK, 32'h0);
    // first result after power-up is discarded
    apb(1'b1, SC, 32'h0);
    wait_done();
    for (int c = 0; c < 31; c++) begin
      if (c > 15 && c < 29 && c != 27) continue;
      er = (c < 15) ? 5'(c) : (c == 29) ? 5'h10 : (c == 30) ? 5'h11 : 5'h12;
      ev = (c < 15) ? {4'(c), 4'h5} : (c == 29) ? 8'hff : 8'h00;
      apb(1'b1, SC, 32'(c));
      // routing output is registered one edge after the write lands
      repeat (2) @(negedge clk);
      check(32'(route), 32'(er));
      wait_done();
      check(rd, 32'h80 | 32'(c));
      apb(1'b0, RS, 32'h0);
      if (er != 5'h12) check(rd, 32'(ev));
      apb(1'b0, SC, 32'h0);
      check(rd, 32'(c));
    end
    apb(1'b1, RS, 32'haa);
    apb(1'b0, RS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, SC, 32'h43);
    wait_irq();
    check(32'(irq), 32'h1);
    apb(1'b0, RS, 32'h0);
    repeat (2) @(negedge clk);
    check({rd[30:0], irq}, 32'h6a);
    apb(1'b1, SC, 32'h43);
    wait_irq();
    apb(1'b1, SC, 32'h5f);
    repeat (2) @(negedge clk);
    check({30'h0, irq, pwr_on}, 32'h0);
    count_sh(300);
    check(32'(n), 32'h0);
    apb(1'b1, SC, 32'h06);
    wait_done();
    count_sh(400);
    check(32'(n), 32'h0);
    apb(1'b1, SC, 32'h27);
    count_sh(600);
    check(32'(n >= 3), 32'h1);
    apb(1'b0, RS, 32'h0);
    check(rd, 32'h75);
    count_sh(300);
    apb(1'b0, SC, 32'h0);
    check(rd, 32'ha7);
    // powered off: no conversion will finish, just let it settle
    apb(1'b1, SC, 32'h1f);
    repeat (20) @(posedge clk);
    for (int p = 0; p < 8; p++) begin
      dv = p[2] ? 16 : (1 << p);
      // clock settings change only while idle
      apb(1'b1, CK, {24'h0, 3'(p), 5'h10});
      apb(1'b1, SC, 32'h03);
      n = 0;
      while (sh !== 1'b1 && n < 300) begin
        @(negedge clk);
        n++;
      end
      w = 0;
      while (sh === 1'b1 && w < 300) begin
        @(negedge clk);
        w++;
      end
      check(32'(w >= 7 * dv && w <= 9 * dv), 32'h1);
      wait_done();
      apb(1'b0, RS, 32'h0);
      if (dv == 16) check(rd, 32'h35);
    end
    apb(1'b1, CK, 32'h0);
    apb(1'b1, SC, 32'h03);
    repeat (20) @(posedge clk);
    stop <= 1'b1;
    count_sh(400);
    check(32'(sh), 32'h0);
    apb(1'b0, SC, 32'h0);
    check(rd, 32'h03);
    stop <= 1'b0;
    end_of_test();
  end
endmodule
`default_nettype wire
